//--- design/pboc_top.sv
`timescale 1ns/1ns
`include "pboc_cfg.svh"

module pboc_top import pboc_pkg::*; #(
  parameter int DW = 24,
  parameter int TZC0 = `PBOC_TZC0_CYC,
  parameter int TZC1 = `PBOC_TZC1_CYC,
  parameter int TZC2 = `PBOC_TZC2_CYC,
  parameter int TZC3 = `PBOC_TZC3_CYC
) (
  input wire logic sys_clk, // Core audio clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [`PBOC_ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte lanes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [`PBOC_ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic frame_i, // One-cycle audio frame strobe.
  input wire logic signed [DW-1:0] beep_smp_i, // Beep path sample.
  input wire pboc_beep_s beep_req_i, // Requested beep gains.
  input wire logic signed [DW-1:0] dac_l_i, // Left DAC input sample.
  input wire logic signed [DW-1:0] dac_r_i, // Right DAC input sample.
  output pboc_beep_s beep_app_o, // Applied beep gains.
  output pboc_ctrl_s ctrl_o, // Static playback controls.
  output logic spk_up_o, // Pulse: start speaker power-up.
  output logic spk_dn_o, // Pulse: start speaker power-down.
  output logic [7:0] atten_l_o, // Applied left attenuator code.
  output logic [7:0] atten_r_o, // Applied right attenuator code.
  output logic signed [DW-1:0] dac_l_o, // Left DAC output sample.
  output logic signed [DW-1:0] dac_r_o // Right DAC output sample.
);
  localparam int CW = 22;

  // All assertions share the core clock and are off during reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // Address decode.
  // ----------------------------------------
  // Misaligned addresses fall outside the map and get an error.
  function automatic pboc_sel_e pboc_sel(input logic [`PBOC_ADDR_W-1:0] a);
    pboc_sel_e s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[`PBOC_ADDR_W-1:2])
        `PBOC_IDX_SPK: s = SEL_SPK;
        `PBOC_IDX_ZCD: s = SEL_ZCD;
        `PBOC_IDX_PWR: s = SEL_PWR;
        `PBOC_IDX_DAC: s = SEL_DAC;
        `PBOC_IDX_ATL: s = SEL_ATL;
        `PBOC_IDX_ATR: s = SEL_ATR;
        `PBOC_IDX_STA: s = SEL_STA;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : pboc_sel

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_hold_ff, w_hold_ff, w_strb_ff;
  logic [`PBOC_ADDR_W-1:0] aw_addr_ff;
  logic [7:0] w_data_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, rd_w;
  logic wr_fire, wr_en;
  pboc_sel_e wsel, rsel;
  pboc_ctrl_s ctrl_ff;
  pboc_beep_s beep_app_ff;
  logic zc_en_ff;
  logic [1:0] zc_tmo_ff;
  logic [7:0] tgt_ff [2];
  logic [7:0] cur_ff [2];
  logic signed [DW-1:0] out_ff [2];
  logic spk_up_ff, spk_dn_ff;
  logic pend_w;

  // ----------------------------------------
  // Write channels.
  // ----------------------------------------
  // Address and data are caught independently; the write happens once both are held.
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wsel = pboc_sel(aw_addr_ff);
  assign wr_en = wr_fire && w_strb_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      awready_ff <= 1'b0;
    end else if (awready_ff && s_axi_awvalid) begin
      aw_hold_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
      awready_ff <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_hold_ff <= 1'b0;
      end
      if (!aw_hold_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
    end
  end

  // Only byte lane 0 carries register bits; the other lanes are ignored.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_hold_ff <= 1'b0;
      w_data_ff <= 8'h00;
      w_strb_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else if (wready_ff && s_axi_wvalid) begin
      w_hold_ff <= 1'b1;
      w_data_ff <= s_axi_wdata[7:0];
      w_strb_ff <= s_axi_wstrb[0];
      wready_ff <= 1'b0;
    end else begin
      if (wr_fire) begin
        w_hold_ff <= 1'b0;
      end
      if (!w_hold_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
    end
  end

  // Response follows both halves; the status register is read-only.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `PBOC_RESP_OK;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wsel == SEL_NONE || wsel == SEL_STA) ? `PBOC_RESP_ERR : `PBOC_RESP_OK;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register file.
  // ----------------------------------------
  // Reserved bits are never stored, so they read back as zero.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= '0;
      zc_en_ff <= `PBOC_RST_ZC_EN;
      zc_tmo_ff <= `PBOC_RST_TMO;
      tgt_ff[0] <= 8'h00;
      tgt_ff[1] <= 8'h00;
    end else if (wr_en) begin
      case (wsel)
        SEL_SPK: begin
          ctrl_ff.spk_gain <= w_data_ff[`PBOC_F_HI2]; // see (R1)
          ctrl_ff.spk_en <= w_data_ff[`PBOC_F_B0]; // see (R3)
        end
        SEL_ZCD: begin
          zc_tmo_ff <= w_data_ff[`PBOC_F_TMO]; // see (R5)
          zc_en_ff <= w_data_ff[`PBOC_F_B0]; // see (R6)
        end
        SEL_PWR: begin
          // The reserved speaker bias code is stored and passed on as written.
          ctrl_ff.spk_bias <= w_data_ff[`PBOC_F_HI2]; // see (R7)
          ctrl_ff.dac_bias <= w_data_ff[`PBOC_F_MID2]; // see (R8)
          ctrl_ff.be_bias <= w_data_ff[`PBOC_F_LO2]; // see (R9)
          ctrl_ff.be_en_r <= w_data_ff[`PBOC_F_B1]; // see (R10)
          ctrl_ff.be_en_l <= w_data_ff[`PBOC_F_B0]; // see (R10)
        end
        SEL_DAC: begin
          ctrl_ff.route <= w_data_ff[`PBOC_F_HI2]; // see (R11)
          ctrl_ff.invert <= w_data_ff[`PBOC_F_INV]; // see (R12)
          ctrl_ff.deemph <= w_data_ff[`PBOC_F_DEEMPH]; // see (R13)
          ctrl_ff.dac_en <= w_data_ff[`PBOC_F_EN2]; // see (R14)
        end
        SEL_ATL: tgt_ff[0] <= w_data_ff; // see (R15)
        SEL_ATR: tgt_ff[1] <= w_data_ff; // see (R15)
        default: ;
      endcase
    end
  end

  // Power sequences start only on a real change of the enable bit.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      spk_up_ff <= 1'b0;
      spk_dn_ff <= 1'b0;
    end else begin
      spk_up_ff <= wr_en && wsel == SEL_SPK && w_data_ff[`PBOC_F_B0] && !ctrl_ff.spk_en; // see (R3)
      spk_dn_ff <= wr_en && wsel == SEL_SPK && !w_data_ff[`PBOC_F_B0] && ctrl_ff.spk_en; // see (R3)
    end
  end

  // ----------------------------------------
  // Read channel.
  // ----------------------------------------
  assign rsel = pboc_sel(s_axi_araddr);

  always_comb begin
    rd_w = 32'h0000_0000;
    case (rsel)
      SEL_SPK: rd_w[7:0] = {ctrl_ff.spk_gain, 5'h00, ctrl_ff.spk_en};
      SEL_ZCD: rd_w[7:0] = {3'h0, zc_tmo_ff, 2'h0, zc_en_ff};
      SEL_PWR: rd_w[7:0] = {ctrl_ff.spk_bias, ctrl_ff.dac_bias, ctrl_ff.be_bias, ctrl_ff.be_en_r, ctrl_ff.be_en_l};
      SEL_DAC: rd_w[7:0] = {ctrl_ff.route, ctrl_ff.invert, 2'h0, ctrl_ff.deemph, ctrl_ff.dac_en};
      SEL_ATL: rd_w[7:0] = tgt_ff[0];
      SEL_ATR: rd_w[7:0] = tgt_ff[1];
      SEL_STA: rd_w = {8'h00, cur_ff[1], cur_ff[0], 5'h00, cur_ff[1] != tgt_ff[1], cur_ff[0] != tgt_ff[0], pend_w};
      default: rd_w = 32'h0000_0000;
    endcase
  end

  // Data is captured at the address handshake and offered on the next cycle.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `PBOC_RESP_OK;
    end else if (arready_ff && s_axi_arvalid) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_w;
      rresp_ff <= (rsel == SEL_NONE) ? `PBOC_RESP_ERR : `PBOC_RESP_OK;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Beep zero-crossing detector.
  // ----------------------------------------
  logic sgn_ff, zc_hit_w, tmo_w, apply_w;
  logic [CW-1:0] cnt_ff, lim_w;

  // A change is pending while the requested gains differ from the applied ones.
  assign pend_w = (beep_req_i != beep_app_ff);
  assign zc_hit_w = frame_i && (beep_smp_i[DW-1] != sgn_ff); // see (R18)
  assign tmo_w = pend_w && (cnt_ff >= lim_w - CW'(1));
  assign apply_w = pend_w && (!zc_en_ff || zc_hit_w || tmo_w); // see (R17)

  always_comb begin
    case (zc_tmo_ff)
      2'h0: lim_w = CW'(TZC0); // see (R5)
      2'h1: lim_w = CW'(TZC1);
      2'h2: lim_w = CW'(TZC2);
      default: lim_w = CW'(TZC3);
    endcase
  end

  // The wait restarts whenever nothing is pending or a change was just applied.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else if (!pend_w || !zc_en_ff || apply_w) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sgn_ff <= 1'b0;
    end else if (frame_i) begin
      sgn_ff <= beep_smp_i[DW-1];
    end
  end

  // All three beep gains move together, on a crossing, a timeout or at once.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      beep_app_ff <= '0;
    end else if (apply_w) begin
      beep_app_ff <= beep_req_i; // see (R4)
    end
  end

  // ----------------------------------------
  // Attenuator slew and DAC datapath.
  // ----------------------------------------
  logic signed [DW:0] mix_w;
  assign mix_w = ((DW+1)'(dac_l_i) + (DW+1)'(dac_r_i)) >>> 1;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic signed [DW-1:0] src, inv, nxt_y;
    logic signed [DW-1:0] y_ff;
    logic signed [DW:0] d;

    // Each frame moves the applied code one 0.375 dB step toward the target.
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        cur_ff[ch] <= 8'h00;
      end else if (frame_i && cur_ff[ch] < tgt_ff[ch]) begin
        cur_ff[ch] <= cur_ff[ch] + 8'h01; // see (R16)
      end else if (frame_i && cur_ff[ch] > tgt_ff[ch]) begin
        cur_ff[ch] <= cur_ff[ch] - 8'h01; // see (R19)
      end
    end

    always_comb begin
      case (ctrl_ff.route)
        2'h0: src = (ch == 0) ? dac_l_i : dac_r_i; // see (R11)
        2'h1: src = dac_l_i;
        2'h2: src = dac_r_i;
        default: src = mix_w[DW-1:0];
      endcase
      // Negating the most negative value would wrap, so it clips instead.
      if (!ctrl_ff.invert) begin
        inv = src;
      end else if (src == {1'b1, {(DW-1){1'b0}}}) begin
        inv = {1'b0, {(DW-1){1'b1}}};
      end else begin
        inv = -src; // see (R12)
      end
      // One-pole shelf; cheap, and the step never overshoots the input.
      d = (DW+1)'(inv) - (DW+1)'(y_ff);
      nxt_y = ctrl_ff.deemph ? y_ff + DW'(d >>> 2) : inv; // see (R13)
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        y_ff <= '0;
        out_ff[ch] <= '0;
      end else if (frame_i) begin
        y_ff <= nxt_y;
        out_ff[ch] <= ctrl_ff.dac_en[ch] ? nxt_y : '0; // see (R14)
      end
    end

    slew_step_a: assert property (frame_i && cur_ff[ch] != tgt_ff[ch] |=> // see (R16)
      (cur_ff[ch] == $past(cur_ff[ch]) + 8'h01) || (cur_ff[ch] == $past(cur_ff[ch]) - 8'h01))
      else $error("attenuator did not move one step");
    slew_stop_a: assert property (cur_ff[ch] == tgt_ff[ch] && !wr_en |=> $stable(cur_ff[ch])) // see (R19)
      else $error("attenuator moved past its target");
  end

  // ----------------------------------------
  // Outputs.
  // ----------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign beep_app_o = beep_app_ff;
  assign ctrl_o = ctrl_ff;
  assign spk_up_o = spk_up_ff;
  assign spk_dn_o = spk_dn_ff;
  assign atten_l_o = cur_ff[0];
  assign atten_r_o = cur_ff[1];
  assign dac_l_o = out_ff[0];
  assign dac_r_o = out_ff[1];

  // ----------------------------------------
  // Assertions.
  // ----------------------------------------

  spk_start_a: assert property ($rose(ctrl_ff.spk_en) |-> spk_up_ff && !spk_dn_ff) // see (R3)
    else $error("speaker enable rose without power-up pulse");
  beep_tmo_a: assert property (zc_en_ff && tmo_w |=> beep_app_ff == $past(beep_req_i)) // see (R4)
    else $error("timeout did not force beep gains");
  zc_apply_a: assert property (zc_en_ff && zc_hit_w && pend_w |=> beep_app_ff == $past(beep_req_i)) // see (R17)
    else $error("crossing did not apply beep gains");
  zc_off_a: assert property (!zc_en_ff && pend_w |=> !$past(pend_w) || beep_app_ff == $past(beep_req_i)) // see (R18)
    else $error("beep gain delayed with detector off");
  zc_hold_a: assert property (zc_en_ff && pend_w && !zc_hit_w && !tmo_w |=> $stable(beep_app_ff)) // see (R17)
    else $error("beep gain changed before crossing or timeout");
  route_left_a: assert property (frame_i && ctrl_ff.route == 2'h1 && ctrl_ff.dac_en == 2'h3
    && !ctrl_ff.deemph |=> dac_l_o == dac_r_o && dac_l_o == $past(ctrl_ff.invert ? -dac_l_i : dac_l_i)) // see (R11)
    else $error("left copy routing wrong");
  dac_off_a: assert property (frame_i && !ctrl_ff.dac_en[0] |=> dac_l_o == '0) // see (R14)
    else $error("disabled left DAC produced output");
  tmo_len_a: assert property (zc_en_ff && zc_tmo_ff == 2'h3 && pend_w |-> cnt_ff < CW'(TZC3)) // see (R5)
    else $error("timeout wait exceeded its limit");

  wr_done_c: cover property (wr_fire ##1 bvalid_ff && s_axi_bready);
  tmo_c: cover property (zc_en_ff && tmo_w);
  zc_c: cover property (zc_en_ff && zc_hit_w && pend_w);
  slew_done_c: cover property (frame_i && cur_ff[0] != tgt_ff[0] ##1 cur_ff[0] == tgt_ff[0]);
endmodule : pboc_top

//--- shared/pboc_cfg.svh
`ifndef PBOC_CFG_SVH
`define PBOC_CFG_SVH
// What this block does
// (R1) Speaker gain field picks 0/2/4/6 dB.
// (R2) Software sets speaker gain once at init.
// (R3) Speaker enable edges start power-up/down sequences.
// (R4) Timeout forces pending beep gains onto all outputs.
// (R5) Timeout field selects 20/10/5/2.5 ms, resets 11.
// (R6) One bit enables zero-crossing detector, resets on.
// (R7) Speaker amp bias: normal, saving, enhanced, reserved.
// (R8) DAC bias field has four bias modes.
// (R9) Back-end bias uses the DAC bias codes.
// (R10) Separate left/right back-end power enables.
// (R11) DAC routing: stereo, left, right, or mix.
// (R12) Polarity bit negates the DAC output.
// (R13) De-emphasis bit applies filter in DAC path.
// (R14) Two DAC enable bits switch channels individually.
// (R15) Eight-bit attenuator codes, 0.375 dB per step.
// (R16) Attenuation slews one step per audio frame.
// (R17) Beep gain applies at crossing or timeout.
// (R18) Sign change is crossing; detector off applies at once.
// (R19) Slew stops at target; new write redirects it.

// ----------------------------------------
// Register indexes; byte address is four times the index.
// ----------------------------------------
`define PBOC_IDX_SPK 16'h4027
`define PBOC_IDX_ZCD 16'h4028
`define PBOC_IDX_PWR 16'h4029
`define PBOC_IDX_DAC 16'h402A
`define PBOC_IDX_ATL 16'h402B
`define PBOC_IDX_ATR 16'h402C
`define PBOC_IDX_STA 16'h40F0
`define PBOC_ADDR_W 18

// ----------------------------------------
// Field positions and reset values.
// ----------------------------------------
`define PBOC_F_HI2 7:6
`define PBOC_F_MID2 5:4
`define PBOC_F_LO2 3:2
`define PBOC_F_TMO 4:3
`define PBOC_F_INV 5
`define PBOC_F_DEEMPH 2
`define PBOC_F_EN2 1:0
`define PBOC_F_B1 1
`define PBOC_F_B0 0
`define PBOC_RST_TMO 2'h3
`define PBOC_RST_ZC_EN 1'h1
`define PBOC_RESP_OK 2'h0
`define PBOC_RESP_ERR 2'h2

// ----------------------------------------
// Zero-crossing timeouts.
// ----------------------------------------
`define PBOC_CLK_MHZ 100
`define PBOC_TZC0_US 20000
`define PBOC_TZC1_US 10000
`define PBOC_TZC2_US 5000
`define PBOC_TZC3_US 2500
`define PBOC_TZC0_CYC (`PBOC_TZC0_US * `PBOC_CLK_MHZ)
`define PBOC_TZC1_CYC (`PBOC_TZC1_US * `PBOC_CLK_MHZ)
`define PBOC_TZC2_CYC (`PBOC_TZC2_US * `PBOC_CLK_MHZ)
`define PBOC_TZC3_CYC (`PBOC_TZC3_US * `PBOC_CLK_MHZ)
`endif

//--- shared/pboc_pkg.sv
package pboc_pkg;
  // Register selected by a bus address.
  typedef enum logic [2:0] {
    SEL_SPK, SEL_ZCD, SEL_PWR, SEL_DAC, SEL_ATL, SEL_ATR, SEL_STA, SEL_NONE
  } pboc_sel_e;

  // Beep gain codes for the three playback beep paths.
  typedef struct packed {
    logic [3:0] mono;
    logic [3:0] right;
    logic [3:0] left;
  } pboc_beep_s;

  // Static controls handed to the analog playback blocks.
  typedef struct packed {
    logic [1:0] spk_gain;
    logic spk_en;
    logic [1:0] spk_bias;
    logic [1:0] dac_bias;
    logic [1:0] be_bias;
    logic be_en_r;
    logic be_en_l;
    logic [1:0] route;
    logic invert;
    logic deemph;
    logic [1:0] dac_en;
  } pboc_ctrl_s;
endpackage : pboc_pkg

//--- tb/tb_top.sv
`timescale 1ns/1ns
`include "pboc_cfg.svh"

module tb_top import pboc_pkg::*; ;
  logic sys_clk, rst_b, awvalid, wvalid, bready, arvalid, rready, frame_i;
  logic awready, wready, bvalid, arready, rvalid, spk_up, spk_dn;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [23:0] beep_smp, dl, dr, dac_l_o, dac_r_o;
  logic [7:0] atl, atr;
  pboc_beep_s breq, bapp;
  pboc_ctrl_s ctrl;
  int fail_count = 0;
  int num_checks = 0;
  int up_n = 0;
  int dn_n = 0;
  int lim [4] = '{80, 40, 20, 10};
  logic [15:0] idx_t [6] = '{16'h4027, 16'h4028, 16'h4029, 16'h402A, 16'h402B, 16'h402C};
  logic [7:0] rst_t [6] = '{8'h00, 8'h19, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [23:0] exp_l [4] = '{24'h000064, 24'h000064, 24'hFFFFD8, 24'h00001E};
  logic [23:0] exp_r [4] = '{24'hFFFFD8, 24'h000064, 24'hFFFFD8, 24'h00001E};

  // Short timeouts keep the zero-crossing waits to tens of cycles.
  pboc_top #(.DW(24), .TZC0(80), .TZC1(40), .TZC2(20), .TZC3(10)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_i(frame_i),
    .beep_smp_i(beep_smp), .beep_req_i(breq), .dac_l_i(dl), .dac_r_i(dr), .beep_app_o(bapp),
    .ctrl_o(ctrl), .spk_up_o(spk_up), .spk_dn_o(spk_dn), .atten_l_o(atl), .atten_r_o(atr),
    .dac_l_o(dac_l_o), .dac_r_o(dac_r_o)
  );

  // ----------------------------------------
  // Clock, pulse counters and watchdog.
  // ----------------------------------------
  // Free-running 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulses last one cycle, so they are counted here rather than polled by the tests.
  always @(posedge sys_clk) begin
    if (spk_up === 1'b1) up_n++;
    if (spk_dn === 1'b1) dn_n++;
  end

  // The tests need well under 3000 cycles; a hang is cut off long after that.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end

  // ----------------------------------------
  // Bus, frame and compare tasks.
  // ----------------------------------------
  // Compare one value and count it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One write; each of AW and W is dropped at its own handshake, bready is raised with them and dropped once bvalid is seen.
  // A hung slave is left to the watchdog.
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  // One read; data and response are taken at the edge where rvalid is seen.
  task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // One frame strobe with its samples; returns once the frame's results have landed.
  task automatic frm(input logic [23:0] b, input logic [23:0] l, input logic [23:0] r);
    @(posedge sys_clk);
    frame_i <= 1'b1;
    beep_smp <= b;
    dl <= l;
    dr <= r;
    @(posedge sys_clk);
    frame_i <= 1'b0;
    #1;
  endtask : frm

  // Print the counts and the verdict, then end the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Test sequence.
  // ----------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, frame_i} = 6'h00;
    awaddr = 18'h00000;
    araddr = 18'h00000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    beep_smp = 24'h000000;
    dl = 24'h000000;
    dr = 24'h000000;
    breq = 12'h000;
    rst_b = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    chk(32'(ctrl), 32'h0);
    for (int i = 0; i < 6; i++) rd(idx_t[i], {24'h0, rst_t[i]}, 2'h0);
    rd(16'h4030, 32'h0, 2'h2);
    wr(16'h4030, 8'h01, 4'h1, 2'h2);
    wr(16'h40F0, 8'h01, 4'h1, 2'h2);
    $display("test reset and map done");
    // Timeout forces the pending gain for every timeout code, muting and unmuting in turn.
    for (int c = 0; c < 4; c++) begin
      wr(16'h4028, {3'h0, c[1:0], 3'h1}, 4'h1, 2'h0);
      @(posedge sys_clk);
      breq <= (c % 2 == 0) ? 12'h456 : 12'h000;
      repeat (lim[c] - 3) @(posedge sys_clk);
      #1;
      chk(bapp, (c % 2 == 0) ? 12'h000 : 12'h456);
      repeat (6) @(posedge sys_clk);
      #1;
      chk(bapp, (c % 2 == 0) ? 12'h456 : 12'h000);
    end
    // Zero crossing applies early; a frame without sign change does not.
    wr(16'h4028, 8'h01, 4'h1, 2'h0);
    frm(24'h000005, 24'h0, 24'h0);
    breq <= 12'h789;
    frm(24'h000007, 24'h0, 24'h0);
    chk(bapp, 12'h000);
    frm(24'hFFFFF0, 24'h0, 24'h0);
    chk(bapp, 12'h789);
    wr(16'h4028, 8'h00, 4'h1, 2'h0);
    breq <= 12'h321;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(bapp, 12'h321);
    $display("test beep gain done");
    // Gain codes are swept while no audio runs; in use the gain is set once, at start-up.
    for (int g = 0; g < 4; g++) begin
      wr(16'h4027, {g[1:0], 6'h01}, 4'h1, 2'h0);
      chk(ctrl.spk_gain, g);
    end
    chk(ctrl.spk_en, 1);
    wr(16'h4027, 8'h00, 4'h1, 2'h0);
    wr(16'h4027, 8'h41, 4'h0, 2'h0);
    rd(16'h4027, 32'h0, 2'h0);
    chk(up_n, 1);
    chk(dn_n, 1);
    wr(16'h4029, 8'hB7, 4'h1, 2'h0);
    chk({ctrl.spk_bias, ctrl.dac_bias, ctrl.be_bias, ctrl.be_en_r, ctrl.be_en_l}, 8'hB7);
    wr(16'h4029, 8'hC8, 4'h1, 2'h0);
    rd(16'h4029, 32'hC8, 2'h0);
    $display("test speaker and power done");
    // Every routing code with both channels on, left 100 and right -40.
    for (int i = 0; i < 4; i++) begin
      wr(16'h402A, {i[1:0], 6'h03}, 4'h1, 2'h0);
      frm(24'h0, 24'h000064, 24'hFFFFD8);
      chk(ctrl.route, i);
      chk({dac_l_o, dac_r_o}, {exp_l[i], exp_r[i]});
    end
    wr(16'h402A, 8'h23, 4'h1, 2'h0);
    frm(24'h0, 24'h000064, 24'hFFFFD8);
    chk({dac_l_o, dac_r_o}, {24'hFFFF9C, 24'h000028});
    wr(16'h402A, 8'h01, 4'h1, 2'h0);
    frm(24'h0, 24'h000064, 24'hFFFFD8);
    chk({dac_l_o, dac_r_o}, {24'h000064, 24'h000000});
    wr(16'h402A, 8'h06, 4'h1, 2'h0);
    chk({ctrl.deemph, ctrl.dac_en}, 3'h6);
    // Right history is -40; with the shelf on, +40 moves it a quarter of the way, to -20.
    frm(24'h0, 24'h0, 24'h000028);
    chk({dac_l_o, dac_r_o}, {24'h000000, 24'hFFFFEC});
    $display("test dac path done");
    // Slew one code per frame, stop on target, then redirect mid-ramp.
    wr(16'h402B, 8'h03, 4'h1, 2'h0);
    for (int i = 1; i < 5; i++) begin
      frm(24'h0, 24'h0, 24'h0);
      chk(atl, (i > 3) ? 3 : i);
    end
    rd(16'h402B, 32'h03, 2'h0);
    wr(16'h402B, 8'h08, 4'h1, 2'h0);
    frm(24'h0, 24'h0, 24'h0);
    chk(atl, 8'h04);
    wr(16'h402B, 8'h02, 4'h1, 2'h0);
    for (int i = 3; i > 1; i--) begin
      frm(24'h0, 24'h0, 24'h0);
      chk(atl, i);
    end
    wr(16'h402C, 8'hFF, 4'h1, 2'h0);
    frm(24'h0, 24'h0, 24'h0);
    chk({atl, atr}, 16'h0201);
    // Status: right applied 1 and still slewing, left applied 2 and settled, no beep pending.
    rd(16'h40F0, 32'h0001_0204, 2'h0);
    $display("test attenuator done");
    stop_test();
  end
endmodule : tb_top
